/* hw/half_bridge_pwm.sv */
// Purpose: half-bridge pwm stage with dead band and auto-shutdown
// Assumes: apb slave, clk is the instruction clock, shutdown inputs synchronous
// Notes:   pin c follows a and pin d follows b for full-bridge use
//
// Functional notes
// R1 - drive pwm on a, complement on b
// R2 - delay active edge by deadband_count cycles
// R3 - delay over duty keeps output inactive
// R4 - software clears direction bits to drive pins
// R5 - auto restart only when auto_restart_en set
// R6 - auto restart: status clears when cause ends
// R7 - no auto restart: status held until software clears
// R8 - resume output at next period start
// R9 - status writes ignored while cause active
// R10 - comparator shutdown is level, blocks clearing
// R11 - writing one to status forces shutdown
// R12 - polarity bits per pair a/c, b/d
// R13 - software sets polarity before enabling outputs
// R14 - software waits one period before output direction
// R15 - period flag set as next period begins
// R16 - all pins high impedance after reset
// R17 - shutdown holds outputs at inactive level
// R18 - dead band restarts at every active edge
`default_nettype none

module half_bridge_pwm (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              shutdownCmp,
  input  wire logic              shutdownExt,
  output pwm_pkg::pin_bus_t      pwmPins,
  output logic                   irq
);

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic setup;
  logic access;
  logic wrAcc;
  logic rdAcc;
  logic mapped;

  assign setup  = psel && !penable;
  assign access = psel && penable;
  assign wrAcc  = access && pwrite && mapped;
  assign rdAcc  = access && !pwrite && mapped;
  assign pready = access;

  always_comb begin
    unique case (paddr)
      pwm_pkg::OFF_CTRL, pwm_pkg::OFF_TIMING, pwm_pkg::OFF_DEADBAND, pwm_pkg::OFF_SHUTDOWN,
      pwm_pkg::OFF_DIR, pwm_pkg::OFF_IRQ_STAT, pwm_pkg::OFF_IRQ_MASK: mapped = 1'b1;
      default:                                                      mapped = 1'b0;
    endcase
  end

  assign pslverr = access && !mapped;

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  pwm_pkg::cfg_t cfg_q;
  pwm_pkg::cfg_t cfg_d;

  always_comb begin
    cfg_d = cfg_q;
    if (wrAcc) begin
      unique case (paddr)
        pwm_pkg::OFF_CTRL: begin
          cfg_d.polaritySel = pwdata[pwm_pkg::POS_POLARITY +: 2];
          cfg_d.enable      = pwdata[pwm_pkg::POS_ENABLE];
        end
        pwm_pkg::OFF_TIMING: begin
          cfg_d.period = pwdata[pwm_pkg::POS_PERIOD +: pwm_pkg::CNT_W];
          cfg_d.duty   = pwdata[pwm_pkg::POS_DUTY +: pwm_pkg::CNT_W];
        end
        pwm_pkg::OFF_DEADBAND: begin
          cfg_d.deadbandCount = pwdata[pwm_pkg::POS_DB_COUNT +: pwm_pkg::DB_W];
          cfg_d.autoRestartEn = pwdata[pwm_pkg::POS_RESTART];
        end
        pwm_pkg::OFF_SHUTDOWN: begin
          cfg_d.cmpEn = pwdata[pwm_pkg::POS_SD_CMP_EN];
          cfg_d.extEn = pwdata[pwm_pkg::POS_SD_EXT_EN];
        end
        pwm_pkg::OFF_DIR:      cfg_d.dir     = pwdata[pwm_pkg::PINS-1:0];
        pwm_pkg::OFF_IRQ_MASK: cfg_d.irqMask = pwdata[pwm_pkg::IRQ_W-1:0];
        default:               cfg_d = cfg_q;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_q.polaritySel   <= pwm_pkg::RST_POLARITY;
      cfg_q.enable        <= 1'b0;
      cfg_q.period        <= pwm_pkg::RST_PERIOD;
      cfg_q.duty          <= pwm_pkg::RST_DUTY;
      cfg_q.deadbandCount <= pwm_pkg::RST_DB_COUNT;
      cfg_q.autoRestartEn <= 1'b0;
      cfg_q.cmpEn         <= 1'b0;
      cfg_q.extEn         <= 1'b0;
      cfg_q.dir           <= pwm_pkg::RST_DIR;
      cfg_q.irqMask       <= pwm_pkg::RST_IRQ;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // ----------------------------------------------------------------
  // period timer
  // ----------------------------------------------------------------
  logic [pwm_pkg::CNT_W-1:0] tmr_q;
  logic [pwm_pkg::CNT_W-1:0] tmr_d;
  logic                      periodStart;

  assign periodStart = cfg_q.enable && (tmr_q == cfg_q.period);

  always_comb begin
    tmr_d = tmr_q;
    if (!cfg_q.enable || periodStart) begin
      tmr_d = '0;
    end else begin
      tmr_d = tmr_q + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tmr_q <= '0;
    end else begin
      tmr_q <= tmr_d;
    end
  end

  // ----------------------------------------------------------------
  // auto-shutdown
  // ----------------------------------------------------------------
  logic sdStatus_q;
  logic sdStatus_d;
  logic forced_q;
  logic forced_d;
  logic cmpCause;
  logic cause;
  logic sdWrite;

  assign cmpCause = cfg_q.cmpEn && shutdownCmp;
  assign cause    = cmpCause || (cfg_q.extEn && shutdownExt);
  assign sdWrite  = wrAcc && (paddr == pwm_pkg::OFF_SHUTDOWN);

  always_comb begin
    sdStatus_d = sdStatus_q;
    forced_d   = forced_q;
    if (cause) begin
      sdStatus_d = 1'b1;                         // cause always wins; writes ignored [R9] [R10]
    end else if (sdWrite && pwdata[pwm_pkg::POS_SD_STATUS]) begin
      sdStatus_d = 1'b1;                         // forced shutdown [R11]
      forced_d   = 1'b1;
    end else if (sdWrite) begin
      sdStatus_d = 1'b0;                         // software clear [R7]
      forced_d   = 1'b0;
    end else if (cfg_q.autoRestartEn && !forced_q) begin
      sdStatus_d = 1'b0;                         // hardware clear once cause gone [R5] [R6]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sdStatus_q <= 1'b0;
      forced_q   <= 1'b0;
    end else begin
      sdStatus_q <= sdStatus_d;
      forced_q   <= forced_d;
    end
  end

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  pwm_pkg::run_state_t run_q;
  pwm_pkg::run_state_t run_d;

  always_comb begin
    run_d = run_q;
    unique case (run_q)
      pwm_pkg::RUN_OFF: begin
        if (cfg_q.enable && !sdStatus_q) begin
          run_d = pwm_pkg::RUN_WAIT;
        end
      end
      pwm_pkg::RUN_WAIT: begin
        if (!cfg_q.enable) begin
          run_d = pwm_pkg::RUN_OFF;
        end else if (periodStart && !sdStatus_q) begin
          run_d = pwm_pkg::RUN_ON;               // resume only at a period boundary [R8]
        end
      end
      pwm_pkg::RUN_ON: begin
        if (!cfg_q.enable) begin
          run_d = pwm_pkg::RUN_OFF;
        end else if (sdStatus_q) begin
          run_d = pwm_pkg::RUN_WAIT;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      run_q <= pwm_pkg::RUN_OFF;
    end else begin
      run_q <= run_d;
    end
  end

  // ----------------------------------------------------------------
  // modulation and dead band
  // ----------------------------------------------------------------
  logic rawPwm;
  logic reqA;
  logic reqB;
  logic actA;
  logic actB;

  assign rawPwm = (run_q == pwm_pkg::RUN_ON) && !sdStatus_q && (tmr_q < cfg_q.duty);
  assign reqA   = rawPwm;                                               // [R1]
  assign reqB   = (run_q == pwm_pkg::RUN_ON) && !sdStatus_q && !rawPwm; // complement [R1] [R17]

  deadband_delay dbA (
    .clk        (clk),
    .rst        (rst),
    .activeReq  (reqA),
    .delayCount (cfg_q.deadbandCount),
    .activeOut  (actA)
  );

  deadband_delay dbB (
    .clk        (clk),
    .rst        (rst),
    .activeReq  (reqB),
    .delayCount (cfg_q.deadbandCount),
    .activeOut  (actB)
  );

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  pwm_pkg::pin_bus_t pins_q;
  pwm_pkg::pin_bus_t pins_d;
  logic              lvlA;
  logic              lvlB;

  always_comb begin
    lvlA      = (actA && !sdStatus_q) ^ cfg_q.polaritySel[0];   // pair a/c [R12] [R17]
    lvlB      = (actB && !sdStatus_q) ^ cfg_q.polaritySel[1];   // pair b/d [R12] [R17]
    pins_d.out = {lvlB, lvlA, lvlB, lvlA};
    pins_d.oe  = ~cfg_q.dir;                                    // driven only once software clears dir [R4]
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pins_q.out <= '0;
      pins_q.oe  <= '0;                                         // high impedance after reset [R16]
    end else begin
      pins_q <= pins_d;
    end
  end

  assign pwmPins = pins_q;

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  logic [pwm_pkg::IRQ_W-1:0] irqStat_q;
  logic [pwm_pkg::IRQ_W-1:0] irqStat_d;
  logic [pwm_pkg::IRQ_W-1:0] irqEvt;
  logic                      irqRead;

  assign irqRead = rdAcc && (paddr == pwm_pkg::OFF_IRQ_STAT);

  always_comb begin
    irqEvt                     = '0;
    irqEvt[pwm_pkg::POS_IRQ_PER] = periodStart;                 // period_timer_flag [R15]
    irqEvt[pwm_pkg::POS_IRQ_SD]  = sdStatus_d && !sdStatus_q;
    irqStat_d = (irqRead ? '0 : irqStat_q) | irqEvt;           // set wins over read clear
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irqStat_q <= pwm_pkg::RST_IRQ;
    end else begin
      irqStat_q <= irqStat_d;
    end
  end

  assign irq = |(irqStat_q & cfg_q.irqMask);

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [31:0] rd_q;
  logic [31:0] rd_d;

  always_comb begin
    rd_d = rd_q;
    if (setup) begin
      rd_d = '0;
      unique case (paddr)
        pwm_pkg::OFF_CTRL: begin
          rd_d[pwm_pkg::POS_POLARITY +: 2] = cfg_q.polaritySel;
          rd_d[pwm_pkg::POS_ENABLE]        = cfg_q.enable;
        end
        pwm_pkg::OFF_TIMING: begin
          rd_d[pwm_pkg::POS_PERIOD +: pwm_pkg::CNT_W] = cfg_q.period;
          rd_d[pwm_pkg::POS_DUTY +: pwm_pkg::CNT_W]   = cfg_q.duty;
        end
        pwm_pkg::OFF_DEADBAND: begin
          rd_d[pwm_pkg::POS_DB_COUNT +: pwm_pkg::DB_W] = cfg_q.deadbandCount;
          rd_d[pwm_pkg::POS_RESTART]                   = cfg_q.autoRestartEn;
        end
        pwm_pkg::OFF_SHUTDOWN: begin
          rd_d[pwm_pkg::POS_SD_STATUS] = sdStatus_q;
          rd_d[pwm_pkg::POS_SD_CMP_EN] = cfg_q.cmpEn;
          rd_d[pwm_pkg::POS_SD_EXT_EN] = cfg_q.extEn;
          rd_d[pwm_pkg::POS_SD_CAUSE]  = cause;
        end
        pwm_pkg::OFF_DIR:      rd_d[pwm_pkg::PINS-1:0]  = cfg_q.dir;
        pwm_pkg::OFF_IRQ_STAT: rd_d[pwm_pkg::IRQ_W-1:0] = irqStat_q;
        pwm_pkg::OFF_IRQ_MASK: rd_d[pwm_pkg::IRQ_W-1:0] = cfg_q.irqMask;
        default:               rd_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_q <= '0;
    end else begin
      rd_q <= rd_d;
    end
  end

  assign prdata = rd_q;

endmodule : half_bridge_pwm

`default_nettype wire

/* pkg/pwm_pkg.sv */
// Purpose: shared constants and types for the half-bridge pwm stage
// Assumes: apb register access, one clock
// Notes:   all offsets are byte addresses of aligned 32-bit words
`default_nettype none

package pwm_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_TIMING   = 8'h04;
  localparam logic [7:0] OFF_DEADBAND = 8'h08;
  localparam logic [7:0] OFF_SHUTDOWN = 8'h0C;
  localparam logic [7:0] OFF_DIR      = 8'h10;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h18;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int POS_POLARITY  = 0;   // output_polarity_sel, 2 bits
  localparam int POS_ENABLE    = 2;
  localparam int POS_PERIOD    = 0;   // 8 bits
  localparam int POS_DUTY      = 8;   // 8 bits
  localparam int POS_DB_COUNT  = 0;   // deadband_count, 7 bits
  localparam int POS_RESTART   = 7;   // auto_restart_en
  localparam int POS_SD_STATUS = 0;   // shutdown_status
  localparam int POS_SD_CMP_EN = 1;
  localparam int POS_SD_EXT_EN = 2;
  localparam int POS_SD_CAUSE  = 3;   // read only
  localparam int POS_IRQ_PER   = 0;   // period_timer_flag
  localparam int POS_IRQ_SD    = 1;

  localparam int DB_W   = 7;
  localparam int CNT_W  = 8;
  localparam int IRQ_W  = 2;
  localparam int PINS   = 4;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [1:0]       RST_POLARITY = 2'h0;
  localparam logic [CNT_W-1:0] RST_PERIOD   = 8'hFF;
  localparam logic [CNT_W-1:0] RST_DUTY     = 8'h00;
  localparam logic [DB_W-1:0]  RST_DB_COUNT = 7'h00;
  localparam logic [PINS-1:0]  RST_DIR      = 4'hF;   // all pins input
  localparam logic [IRQ_W-1:0] RST_IRQ      = 2'h0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {RUN_OFF, RUN_WAIT, RUN_ON} run_state_t;

  typedef struct packed {
    logic [PINS-1:0] out;   // pin level, bit0 = pwm_out_a .. bit3 = pwm_out_d
    logic [PINS-1:0] oe;    // high while the pin is driven
  } pin_bus_t;

  typedef struct packed {
    logic [1:0]       polaritySel;
    logic             enable;
    logic [CNT_W-1:0] period;
    logic [CNT_W-1:0] duty;
    logic [DB_W-1:0]  deadbandCount;
    logic             autoRestartEn;
    logic             cmpEn;
    logic             extEn;
    logic [PINS-1:0]  dir;
    logic [IRQ_W-1:0] irqMask;
  } cfg_t;

endpackage : pwm_pkg

`default_nettype wire

/* hw/deadband_delay.sv */
// Purpose: delays the inactive-to-active edge of one output
// Assumes: request and count synchronous to clk
// Notes:   falling edge of the request passes after one register
`default_nettype none

module deadband_delay (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   activeReq,
  input  wire logic [pwm_pkg::DB_W-1:0] delayCount,
  output logic                        activeOut
);

  logic [pwm_pkg::DB_W-1:0] cnt_q;
  logic [pwm_pkg::DB_W-1:0] cnt_d;
  logic                     out_q;
  logic                     out_d;

  always_comb begin
    cnt_d = cnt_q;
    out_d = out_q;
    if (!activeReq) begin
      cnt_d = delayCount;              // reload while inactive [R18]
      out_d = 1'b0;
    end else if (cnt_q == '0) begin
      out_d = 1'b1;                    // active only after full delay [R2]
    end else begin
      cnt_d = cnt_q - 7'h01;           // request shorter than delay never activates [R3]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= pwm_pkg::RST_DB_COUNT;
      out_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end

  assign activeOut = out_q;

endmodule : deadband_delay

`default_nettype wire

/* testbench/pwm_monitor.sv */
// Purpose: port checker for half_bridge_pwm
// Assumes: written fields are shadowed from the apb bus
// Notes:   active level of a pin is its level xor the shadowed polarity
`default_nettype none

module pwm_monitor (
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [7:0]        paddr,
  input wire logic [31:0]       pwdata,
  input wire logic              shutdownCmp,
  input wire pwm_pkg::pin_bus_t pwmPins,
  input wire logic              irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] polW;
  logic [1:0] polQ;
  logic [6:0] dbQ;
  logic       cmpEnQ;
  logic [1:0] maskQ;
  logic [7:0] idleQ;
  logic       wr;
  logic       actA;
  logic       actB;
  assign wr   = psel && penable && pwrite;
  assign actA = pwmPins.out[0] ^ polQ[0];
  assign actB = pwmPins.out[1] ^ polQ[1];
  // idleQ counts cycles with both outputs inactive, saturating
  always_ff @(posedge clk) begin
    if (rst) begin
      polW   <= 2'h0;
      polQ   <= 2'h0;
      dbQ    <= 7'h00;
      cmpEnQ <= 1'b0;
      maskQ  <= 2'h0;
      idleQ  <= 8'h00;
    end else begin
      // the pins show a new polarity one register later than the write
      if (wr && paddr == pwm_pkg::OFF_CTRL) polW <= pwdata[1:0];
      polQ <= polW;
      if (wr && paddr == pwm_pkg::OFF_DEADBAND) dbQ <= pwdata[6:0];
      if (wr && paddr == pwm_pkg::OFF_SHUTDOWN) cmpEnQ <= pwdata[1];
      if (wr && paddr == pwm_pkg::OFF_IRQ_MASK) maskQ <= pwdata[1:0];
      if (actA || actB) idleQ <= 8'h00;
      else if (idleQ != 8'hFF) idleQ <= idleQ + 8'h01;
    end
  end
  // ----
  // checks
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_reset_hiz: assert property ($fell(rst) |-> pwmPins.oe == 4'h0 [*2])
    else $error("pins driven after reset");
  a_pair_mirror: assert property (pwmPins.out[3:2] == pwmPins.out[1:0])
    else $error("pair levels differ");
  a_no_overlap: assert property (!(actA && actB))
    else $error("both outputs active");
  a_deadband_gap: assert property ($rose(actA) || $rose(actB) |-> idleQ >= {1'b0, dbQ})
    else $error("dead band too short");
  a_force_off: assert property (wr && paddr == pwm_pkg::OFF_SHUTDOWN && pwdata[0]
    |-> ##[1:2] (!actA && !actB) [*4]) else $error("forced shutdown ignored");
  a_cmp_level: assert property ((shutdownCmp && cmpEnQ) [*3] |-> !actA && !actB)
    else $error("output active during comparator shutdown");
  a_dir_oe: assert property (wr && paddr == pwm_pkg::OFF_DIR |-> ##2 pwmPins.oe == ~$past(pwdata[3:0], 2))
    else $error("output enable does not follow direction");
  a_irq_masked: assert property (irq |-> maskQ != 2'h0)
    else $error("interrupt while fully masked");
  c_pulse: cover property (actA ##1 !actA);
  c_cmp: cover property ((shutdownCmp && cmpEnQ) [*3]);
  c_irq: cover property ($rose(irq));
endmodule : pwm_monitor

bind half_bridge_pwm pwm_monitor i_mon (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .shutdownCmp,
                                        .pwmPins, .irq);

`default_nettype wire

/* testbench/bridge_stage.sv */
// Purpose: power switch pair driven by the pwm pins
// Assumes: a switch conducts while its gate is at its active level
// Notes:   counts cycles where both switches of a leg conduct
`default_nettype none

module bridge_stage (
  input  wire logic              clk,
  input  wire pwm_pkg::pin_bus_t pwmPins,
  input  wire logic [1:0]        actLow,
  output logic [3:0]             gate,
  output int                     shootCnt
);
  timeunit 1ns;
  timeprecision 1ps;
  // released pins are pulled to the level that keeps the switch off
  always_comb begin
    for (int i = 0; i < 4; i++) gate[i] = pwmPins.oe[i] ? pwmPins.out[i] : actLow[i % 2];
  end
  initial shootCnt = 0;
  always @(posedge clk) begin
    if ((gate[0] ^ actLow[0]) && (gate[1] ^ actLow[1])) shootCnt++;
  end
endmodule : bridge_stage

`default_nettype wire

/* testbench/tb_top.sv */
// Purpose: self-checking bench for half_bridge_pwm
// Assumes: zero-wait apb slave, pins sampled every cycle
// Notes:   period 39, duty 12, dead band 5
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // dut and load
  // ----
  logic              clk, rst, psel, penable, pwrite, pready, pslverr, shutdownCmp, shutdownExt, irq;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata, rdata;
  logic [1:0]        actLow;
  logic [3:0]        gate;
  logic              errSeen;
  pwm_pkg::pin_bus_t pwmPins;
  int                errCount, totalChecks, cycles, shootCnt, hiA, hiB;
  half_bridge_pwm i_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
                         .shutdownCmp, .shutdownExt, .pwmPins, .irq);
  bridge_stage i_load (.clk, .pwmPins, .actLow, .gate, .shootCnt);
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errCount++;
      giveVerdict();
    end
  end
  // ----
  // tasks
  // ----
  task automatic giveVerdict();
    if (errCount == 0 && totalChecks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : giveVerdict
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    totalChecks++;
    if (got !== exp) begin
      errCount++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdata   = prdata;
    errSeen = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
    apb(1'b0, a, 32'h0);
    chk(name, exp, rdata);
  endtask : rd
  task automatic measure();
    hiA = 0;
    hiB = 0;
    // skip one period: the first period after a restart lacks the b pulse carried over into count 0
    repeat (40) @(posedge clk);
    repeat (40) begin
      @(posedge clk);
      hiA += pwmPins.out[0];
      hiB += pwmPins.out[1];
    end
  endtask : measure
  task automatic waitIrq();
    int n;
    n   = 0;
    hiA = 0;
    hiB = 0;
    while (irq !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
      hiA += pwmPins.out[0];
      hiB += pwmPins.out[1];
    end
    chk("irqRise", 32'h1, irq);
  endtask : waitIrq
  // ----
  // sequence
  // ----
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    shutdownCmp = 1'b0;
    shutdownExt = 1'b0;
    actLow = 2'h0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    chk("oeReset", 32'h0, pwmPins.oe);
    rd(pwm_pkg::OFF_DIR, 32'hF, "dirReset");
    rd(pwm_pkg::OFF_TIMING, 32'hFF, "timingReset");
    rd(pwm_pkg::OFF_CTRL, 32'h0, "ctrlReset");
    apb(1'b0, 8'h1C, 32'h0);
    chk("unmappedErr", 32'h1, errSeen);
    wr(pwm_pkg::OFF_IRQ_MASK, 32'h3);
    wr(pwm_pkg::OFF_TIMING, 32'h0C27);
    wr(pwm_pkg::OFF_DEADBAND, 32'h5);
    wr(pwm_pkg::OFF_CTRL, 32'h4);
    apb(1'b0, pwm_pkg::OFF_IRQ_STAT, 32'h0);
    waitIrq();
    rd(pwm_pkg::OFF_IRQ_STAT, 32'h1, "periodFlag");
    rd(pwm_pkg::OFF_IRQ_STAT, 32'h0, "flagCleared");
    wr(pwm_pkg::OFF_DIR, 32'h0);
    measure();
    chk("highA", 32'd7, hiA);
    chk("highB", 32'd23, hiB);
    wr(pwm_pkg::OFF_SHUTDOWN, 32'h1);
    measure();
    chk("forcedA", 32'd0, hiA);
    chk("forcedB", 32'd0, hiB);
    // the longer dead band is loaded only while the outputs are held off
    wr(pwm_pkg::OFF_DEADBAND, 32'hF);
    apb(1'b0, pwm_pkg::OFF_IRQ_STAT, 32'h0);
    wr(pwm_pkg::OFF_SHUTDOWN, 32'h0);
    waitIrq();
    chk("restartEarly", 32'd0, hiA + hiB);
    measure();
    chk("longDbA", 32'd0, hiA);
    chk("longDbB", 32'd13, hiB);
    wr(pwm_pkg::OFF_SHUTDOWN, 32'h1);
    wr(pwm_pkg::OFF_DIR, 32'hF);
    wr(pwm_pkg::OFF_CTRL, 32'h5);
    actLow <= 2'h1;
    wr(pwm_pkg::OFF_DEADBAND, 32'h5);
    wr(pwm_pkg::OFF_DIR, 32'h0);
    wr(pwm_pkg::OFF_SHUTDOWN, 32'h0);
    apb(1'b0, pwm_pkg::OFF_IRQ_STAT, 32'h0);
    waitIrq();
    measure();
    chk("lowActiveA", 32'd33, hiA);
    chk("highActiveB", 32'd23, hiB);
    wr(pwm_pkg::OFF_DEADBAND, 32'h85);
    wr(pwm_pkg::OFF_SHUTDOWN, 32'h6);
    shutdownExt <= 1'b1;
    repeat (2) @(posedge clk);
    rd(pwm_pkg::OFF_SHUTDOWN, 32'hF, "extHeld");
    wr(pwm_pkg::OFF_SHUTDOWN, 32'h6);
    rd(pwm_pkg::OFF_SHUTDOWN, 32'hF, "writeIgnored");
    shutdownExt <= 1'b0;
    repeat (2) @(posedge clk);
    rd(pwm_pkg::OFF_SHUTDOWN, 32'h6, "autoCleared");
    wr(pwm_pkg::OFF_DEADBAND, 32'h5);
    shutdownExt <= 1'b1;
    repeat (2) @(posedge clk);
    shutdownExt <= 1'b0;
    repeat (2) @(posedge clk);
    rd(pwm_pkg::OFF_SHUTDOWN, 32'h7, "statusSticky");
    shutdownCmp <= 1'b1;
    repeat (4) @(posedge clk);
    wr(pwm_pkg::OFF_SHUTDOWN, 32'h6);
    rd(pwm_pkg::OFF_SHUTDOWN, 32'hF, "cmpLevel");
    shutdownCmp <= 1'b0;
    repeat (2) @(posedge clk);
    wr(pwm_pkg::OFF_SHUTDOWN, 32'h6);
    rd(pwm_pkg::OFF_SHUTDOWN, 32'h6, "swCleared");
    wr(pwm_pkg::OFF_IRQ_MASK, 32'h2);
    chk("irqEvent", 32'h1, irq);
    wr(pwm_pkg::OFF_IRQ_MASK, 32'h0);
    chk("irqMasked", 32'h0, irq);
    apb(1'b0, pwm_pkg::OFF_IRQ_STAT, 32'h0);
    chk("eventBit", 32'h1, rdata[1]);
    wr(pwm_pkg::OFF_IRQ_MASK, 32'h2);
    chk("irqCleared", 32'h0, irq);
    chk("shootThrough", 32'h0, shootCnt);
    giveVerdict();
  end
endmodule : tb_top

`default_nettype wire
